/* core/plsc_ctrl.v */
// input clock selection, holdover, loop bandwidth and calibration squelch control
// assumes a same-clock register port from the serial management logic and
// quality flags from the alarm logic; the select pin is asynchronous
//
// Notes on behaviour
// - bits 7:4 of bandwidth register choose the loop bandwidth
// - new bandwidth applies only after a calibration; the INTERNAL_CAL_START input starts one
// - manual register mode: code 00 picks input one, 01 input two
// - manual pin mode: the select pin decides, register field ignored
// - hold bit forces holdover, overriding all selection controls
// - during forced hold input quality is ignored; clearing restores selection
// - squelch bit 1 disables outputs during calibration, 0 keeps them running
// - method 00 manual, 01 auto non-revertive, 10 auto revertive, 11 reserved
// - bits 4:0 of method register set the history delay
// - bits 7:6 set CMOS drive strength, lowest 00 to highest 11
// - always-enabled control overrides squelch and keeps outputs driven
`timescale 1ns/1ps
`include "plsc_regs.vh"

module plsc_ctrl #(
    parameter CAL_CYCLES = 1000
) (
    // clock and reset
    input wire CLOCK,
    input wire RESET_N,
    // register port
    input wire [7:0] REG_ADDR,
    input wire REG_WR_EN,
    input wire [7:0] REG_WR_DATA,
    input wire REG_RD_EN,
    output reg [7:0] REG_RD_DATA,
    // configuration and status from neighbouring logic
    input wire PIN_SELECT_ENABLE,
    input wire OUTPUT_ALWAYS_ENABLED,
    input wire CMOS_FORMAT,
    input wire INPUT_ONE_VALID,
    input wire INPUT_TWO_VALID,
    input wire INTERNAL_CAL_START,
    // external select pin
    input wire SELECT_INPUT_PIN,
    // control outputs
    output reg [3:0] LOOP_BW_ACTIVE,
    output reg CAL_BUSY,
    output reg OUTPUT_CLOCK_ENABLE,
    output reg ACTIVE_INPUT_ONE,
    output reg ACTIVE_INPUT_TWO,
    output reg HOLDOVER_ACTIVE,
    output reg [4:0] HISTORY_DELAY,
    output reg [1:0] CMOS_DRIVE_STRENGTH,
    output reg CMOS_DRIVE_VALID
);

    // selection states
    localparam [2:0] ST_ONE = 3'h1;
    localparam [2:0] ST_TWO = 3'h2;
    localparam [2:0] ST_HOLD = 3'h4;

    // calibration states
    localparam [1:0] CAL_IDLE = 2'h1;
    localparam [1:0] CAL_RUN = 2'h2;

    localparam [31:0] CAL_LAST = CAL_CYCLES - 1;

    reg [7:0] loop_bw_q;
    reg [7:0] sel_hold_q;
    reg [7:0] method_q;
    reg [7:0] cmos_q;
    reg [2:0] sel_state_q;
    reg [2:0] sel_state_d;
    reg [1:0] cal_state_q;
    reg [31:0] cal_count_q;
    reg [2:0] pin_sync_q;
    reg pin_level_q;

    wire [1:0] input_sel_field;
    wire [1:0] method_field;
    wire force_hold;
    wire squelch_during_cal;
    wire cal_done;

    // merge writable bits into a register, leaving reserved ones alone
    function [7:0] wr_merge;
        input [7:0] old_val;
        input [7:0] new_val;
        input [7:0] wmask;
        begin
            wr_merge = (old_val & ~wmask) | (new_val & wmask);
        end
    endfunction

    assign input_sel_field = sel_hold_q[`PLSC_INPUT_SEL_FIELD];
    assign method_field = method_q[`PLSC_METHOD_FIELD];
    assign force_hold = sel_hold_q[`PLSC_HOLD_BIT];
    assign squelch_during_cal = sel_hold_q[`PLSC_SQUELCH_BIT];
    assign cal_done = (cal_state_q == CAL_RUN) && (cal_count_q == CAL_LAST);

    // register writes
    always @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            loop_bw_q <= `PLSC_RST_LOOP_BW;
            sel_hold_q <= `PLSC_RST_SEL_HOLD;
            method_q <= `PLSC_RST_METHOD;
            cmos_q <= `PLSC_RST_CMOS;
        end
        else if (REG_WR_EN)
        begin
            if (REG_ADDR == `PLSC_OFS_LOOP_BW)
            begin
                loop_bw_q <= wr_merge(loop_bw_q, REG_WR_DATA, `PLSC_WMASK_LOOP_BW);
            end
            else if (REG_ADDR == `PLSC_OFS_SEL_HOLD)
            begin
                sel_hold_q <= wr_merge(sel_hold_q, REG_WR_DATA, `PLSC_WMASK_SEL_HOLD);
            end
            else if (REG_ADDR == `PLSC_OFS_METHOD)
            begin
                method_q <= wr_merge(method_q, REG_WR_DATA, `PLSC_WMASK_METHOD);
            end
            else if (REG_ADDR == `PLSC_OFS_CMOS)
            begin
                cmos_q <= wr_merge(cmos_q, REG_WR_DATA, `PLSC_WMASK_CMOS);
            end
        end
    end

    // register reads
    always @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            REG_RD_DATA <= `PLSC_RD_UNMAPPED;
        end
        else if (REG_RD_EN)
        begin
            if (REG_ADDR == `PLSC_OFS_LOOP_BW)
            begin
                REG_RD_DATA <= loop_bw_q;
            end
            else if (REG_ADDR == `PLSC_OFS_SEL_HOLD)
            begin
                REG_RD_DATA <= sel_hold_q;
            end
            else if (REG_ADDR == `PLSC_OFS_METHOD)
            begin
                REG_RD_DATA <= method_q;
            end
            else if (REG_ADDR == `PLSC_OFS_CMOS)
            begin
                REG_RD_DATA <= cmos_q;
            end
            else
            begin
                REG_RD_DATA <= `PLSC_RD_UNMAPPED;
            end
        end
    end

    // select pin synchroniser, change taken when stages two and three agree
    always @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pin_sync_q <= 3'h0;
            pin_level_q <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], SELECT_INPUT_PIN};
            if (pin_sync_q[1] == pin_sync_q[2])
            begin
                pin_level_q <= pin_sync_q[2];
            end
        end
    end

    // calibration sequencer
    always @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cal_state_q <= CAL_IDLE;
            cal_count_q <= 32'h0;
            LOOP_BW_ACTIVE <= `PLSC_RST_BW_ACTIVE;
        end
        else
        begin
            case (cal_state_q)
                CAL_IDLE:
                begin
                    cal_count_q <= 32'h0;
                    if (INTERNAL_CAL_START)
                    begin
                        cal_state_q <= CAL_RUN;
                    end
                end
                CAL_RUN:
                begin
                    cal_count_q <= cal_count_q + 32'h1;
                    if (cal_done)
                    begin
                        cal_state_q <= CAL_IDLE;
                        LOOP_BW_ACTIVE <= loop_bw_q[`PLSC_LOOP_BW_FIELD];
                    end
                end
                default:
                begin
                    cal_state_q <= CAL_IDLE;
                end
            endcase
        end
    end

    // input selection
    always @*
    begin
        sel_state_d = sel_state_q;
        if (force_hold)
        begin
            sel_state_d = ST_HOLD;
        end
        else if (method_field == `PLSC_METHOD_MANUAL)
        begin
            if (PIN_SELECT_ENABLE)
            begin
                sel_state_d = pin_level_q ? ST_TWO : ST_ONE;
            end
            else if (input_sel_field == `PLSC_SEL_INPUT_ONE)
            begin
                sel_state_d = ST_ONE;
            end
            else if (input_sel_field == `PLSC_SEL_INPUT_TWO)
            begin
                sel_state_d = ST_TWO;
            end
        end
        else if (method_field == `PLSC_METHOD_REVERT)
        begin
            if (INPUT_ONE_VALID)
            begin
                sel_state_d = ST_ONE;
            end
            else if (INPUT_TWO_VALID)
            begin
                sel_state_d = ST_TWO;
            end
            else
            begin
                sel_state_d = ST_HOLD;
            end
        end
        else if (method_field == `PLSC_METHOD_NONREVERT)
        begin
            case (sel_state_q)
                ST_ONE:
                begin
                    if (!INPUT_ONE_VALID)
                    begin
                        sel_state_d = INPUT_TWO_VALID ? ST_TWO : ST_HOLD;
                    end
                end
                ST_TWO:
                begin
                    if (!INPUT_TWO_VALID)
                    begin
                        sel_state_d = INPUT_ONE_VALID ? ST_ONE : ST_HOLD;
                    end
                end
                default:
                begin
                    if (INPUT_ONE_VALID)
                    begin
                        sel_state_d = ST_ONE;
                    end
                    else if (INPUT_TWO_VALID)
                    begin
                        sel_state_d = ST_TWO;
                    end
                end
            endcase
        end
    end

    always @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sel_state_q <= ST_ONE;
        end
        else
        begin
            sel_state_q <= sel_state_d;
        end
    end

    // registered status and control outputs
    always @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            CAL_BUSY <= 1'b0;
            OUTPUT_CLOCK_ENABLE <= 1'b1;
            ACTIVE_INPUT_ONE <= 1'b1;
            ACTIVE_INPUT_TWO <= 1'b0;
            HOLDOVER_ACTIVE <= 1'b0;
            HISTORY_DELAY <= 5'h0;
            CMOS_DRIVE_STRENGTH <= 2'h0;
            CMOS_DRIVE_VALID <= 1'b0;
        end
        else
        begin
            CAL_BUSY <= (cal_state_q == CAL_RUN);
            OUTPUT_CLOCK_ENABLE <= OUTPUT_ALWAYS_ENABLED || !squelch_during_cal || (cal_state_q != CAL_RUN);
            ACTIVE_INPUT_ONE <= (sel_state_q == ST_ONE);
            ACTIVE_INPUT_TWO <= (sel_state_q == ST_TWO);
            HOLDOVER_ACTIVE <= (sel_state_q == ST_HOLD);
            HISTORY_DELAY <= method_q[`PLSC_HISTORY_DELAY_FIELD];
            CMOS_DRIVE_STRENGTH <= cmos_q[`PLSC_CMOS_FIELD];
            CMOS_DRIVE_VALID <= CMOS_FORMAT;
        end
    end

endmodule // plsc_ctrl

/* core/plsc_regs.vh */
// register offsets, reset values, write masks and field codes
// of the input select and loop control block
`ifndef PLSC_REGS_VH
`define PLSC_REGS_VH

// register offsets
`define PLSC_OFS_LOOP_BW 8'h02
`define PLSC_OFS_SEL_HOLD 8'h03
`define PLSC_OFS_METHOD 8'h04
`define PLSC_OFS_CMOS 8'h05

// reset values
`define PLSC_RST_LOOP_BW 8'h42
`define PLSC_RST_SEL_HOLD 8'h05
`define PLSC_RST_METHOD 8'h12
`define PLSC_RST_CMOS 8'hed
`define PLSC_RST_BW_ACTIVE 4'h4

// writable bits, the rest hold their reset value
`define PLSC_WMASK_LOOP_BW 8'hf0
`define PLSC_WMASK_SEL_HOLD 8'hf0
`define PLSC_WMASK_METHOD 8'hdf
`define PLSC_WMASK_CMOS 8'hc0

// field positions
`define PLSC_LOOP_BW_FIELD 7:4
`define PLSC_INPUT_SEL_FIELD 7:6
`define PLSC_HOLD_BIT 5
`define PLSC_SQUELCH_BIT 4
`define PLSC_METHOD_FIELD 7:6
`define PLSC_HISTORY_DELAY_FIELD 4:0
`define PLSC_CMOS_FIELD 7:6

// input select codes
`define PLSC_SEL_INPUT_ONE 2'h0
`define PLSC_SEL_INPUT_TWO 2'h1

// selection method codes
`define PLSC_METHOD_MANUAL 2'h0
`define PLSC_METHOD_NONREVERT 2'h1
`define PLSC_METHOD_REVERT 2'h2

// read answer for unmapped offsets
`define PLSC_RD_UNMAPPED 8'h00

`endif

/* verification/plsc_ctrl_monitor.sv */
// assertion checker for the input select and loop control block
// sees only top ports; bound into every plsc_ctrl instance
`timescale 1ns/1ps
`include "plsc_regs.vh"
module plsc_ctrl_check #(
    parameter CAL_CYCLES = 1000
) (
    // clock and reset
    input wire CLOCK,
    input wire RESET_N,
    // register port
    input wire [7:0] REG_ADDR,
    input wire REG_WR_EN,
    input wire [7:0] REG_WR_DATA,
    // select controls
    input wire PIN_SELECT_ENABLE,
    input wire SELECT_INPUT_PIN,
    // watched outputs
    input wire [3:0] LOOP_BW_ACTIVE,
    input wire CAL_BUSY,
    input wire OUTPUT_CLOCK_ENABLE,
    input wire ACTIVE_INPUT_ONE,
    input wire ACTIVE_INPUT_TWO,
    input wire HOLDOVER_ACTIVE,
    input wire [4:0] HISTORY_DELAY
);
    reg [1:0] meth_q;
    reg hold_q;
    reg [3:0] bw_q;
    reg [15:0] busy_cnt_q;
    wire wr_sel = REG_WR_EN && REG_ADDR == `PLSC_OFS_SEL_HOLD;
    wire wr_meth = REG_WR_EN && REG_ADDR == `PLSC_OFS_METHOD;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // shadow of written fields and calibration length count
    always @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            meth_q <= 2'h0;
            hold_q <= 1'b0;
            bw_q <= 4'h4;
            busy_cnt_q <= 16'h0;
        end
        else
        begin
            if (wr_meth)
                meth_q <= REG_WR_DATA[7:6];
            if (wr_sel)
                hold_q <= REG_WR_DATA[5];
            if (REG_WR_EN && REG_ADDR == `PLSC_OFS_LOOP_BW)
                bw_q <= REG_WR_DATA[7:4];
            busy_cnt_q <= CAL_BUSY ? busy_cnt_q + 16'h1 : 16'h0;
        end
    end
    property p_onehot;
        $onehot({ACTIVE_INPUT_ONE, ACTIVE_INPUT_TWO, HOLDOVER_ACTIVE});
    endproperty
    a_onehot: assert property (p_onehot) else $error("selection not one-hot");
    property p_hold;
        wr_sel && REG_WR_DATA[5] |-> ##3 HOLDOVER_ACTIVE;
    endproperty
    a_hold: assert property (p_hold) else $error("hold write not obeyed");
    property p_manual;
        wr_sel && REG_WR_DATA[7:5] == 3'b010 && meth_q == 2'h0 && !PIN_SELECT_ENABLE |-> ##3 ACTIVE_INPUT_TWO;
    endproperty
    a_manual: assert property (p_manual) else $error("register select ignored");
    property p_pin;
        (meth_q == 2'h0 && !hold_q && PIN_SELECT_ENABLE && SELECT_INPUT_PIN)[*7] |-> ACTIVE_INPUT_TWO;
    endproperty
    a_pin: assert property (p_pin) else $error("select pin ignored");
    property p_cal_len;
        $fell(CAL_BUSY) |-> busy_cnt_q == CAL_CYCLES;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_out_idle;
        !CAL_BUSY |-> OUTPUT_CLOCK_ENABLE;
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("output off outside calibration");
    property p_bw;
        $fell(CAL_BUSY) |-> LOOP_BW_ACTIVE == bw_q;
    endproperty
    a_bw: assert property (p_bw) else $error("bandwidth not applied");
    property p_hist;
        wr_meth |-> ##2 HISTORY_DELAY == $past(REG_WR_DATA[4:0], 2);
    endproperty
    a_hist: assert property (p_hist) else $error("history delay wrong");
endmodule // plsc_ctrl_check

bind plsc_ctrl plsc_ctrl_check #(.CAL_CYCLES(CAL_CYCLES)) plsc_ctrl_check_inst (.*);

/* verification/tb_top.sv */
// self-checking bench for the input select and loop control block
// drives inputs at the falling edge; checker is bound from its own file
`timescale 1ns/1ps
`include "plsc_regs.vh"
module tb_top;
    reg CLOCK = 1'b0;
    reg RESET_N = 1'b0;
    reg [7:0] REG_ADDR = 8'h00;
    reg REG_WR_EN = 1'b0;
    reg [7:0] REG_WR_DATA = 8'h00;
    reg REG_RD_EN = 1'b0;
    reg PIN_SELECT_ENABLE = 1'b0;
    reg OUTPUT_ALWAYS_ENABLED = 1'b0;
    reg CMOS_FORMAT = 1'b1;
    reg INPUT_ONE_VALID = 1'b1;
    reg INPUT_TWO_VALID = 1'b1;
    reg INTERNAL_CAL_START = 1'b0;
    reg SELECT_INPUT_PIN = 1'b0;
    wire [7:0] REG_RD_DATA;
    wire [3:0] LOOP_BW_ACTIVE;
    wire [4:0] HISTORY_DELAY;
    wire [1:0] CMOS_DRIVE_STRENGTH;
    wire CAL_BUSY, OUTPUT_CLOCK_ENABLE, ACTIVE_INPUT_ONE, ACTIVE_INPUT_TWO, HOLDOVER_ACTIVE, CMOS_DRIVE_VALID;
    localparam [31:0] RSTS = {`PLSC_RST_CMOS, `PLSC_RST_METHOD, `PLSC_RST_SEL_HOLD, `PLSC_RST_LOOP_BW};
    localparam [31:0] MSKS = {`PLSC_WMASK_CMOS, `PLSC_WMASK_METHOD, `PLSC_WMASK_SEL_HOLD, `PLSC_WMASK_LOOP_BW};
    integer bad_count = 0;
    integer samples_checked = 0;
    integer i;
    reg [7:0] rd_val;
    reg [7:0] bw_exp;
    plsc_ctrl #(.CAL_CYCLES(8)) plsc_ctrl_inst (.*);
    initial forever #12.5 CLOCK = ~CLOCK;
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(negedge CLOCK);
        REG_ADDR = a;
        REG_WR_DATA = d;
        REG_WR_EN = 1'b1;
        @(negedge CLOCK);
        REG_WR_EN = 1'b0;
    end
    endtask
    task rd(input [7:0] a);
    begin
        @(negedge CLOCK);
        REG_ADDR = a;
        REG_RD_EN = 1'b1;
        @(negedge CLOCK);
        REG_RD_EN = 1'b0;
        rd_val = REG_RD_DATA;
    end
    endtask
    task sel(input [2:0] e);
    begin
        repeat (8) @(negedge CLOCK);
        chk({5'h0, ACTIVE_INPUT_ONE, ACTIVE_INPUT_TWO, HOLDOVER_ACTIVE}, {5'h0, e});
    end
    endtask
    task wait_busy(input b);
        integer n;
    begin
        n = 0;
        while (CAL_BUSY !== b && n < 40)
        begin
            @(negedge CLOCK);
            n = n + 1;
        end
        if (CAL_BUSY !== b)
        begin
            bad_count = bad_count + 1;
            end_sim;
        end
    end
    endtask
    initial
    begin
        repeat (6) @(negedge CLOCK);
        RESET_N = 1'b1;
        @(negedge CLOCK);
        chk(HISTORY_DELAY, 8'h12);
        for (i = 0; i < 4; i = i + 1)
        begin
            rd(`PLSC_OFS_LOOP_BW + i[7:0]);
            chk(rd_val, RSTS[i*8 +: 8]);
            wr(`PLSC_OFS_LOOP_BW + i[7:0], 8'hff);
            rd(`PLSC_OFS_LOOP_BW + i[7:0]);
            chk(rd_val, RSTS[i*8 +: 8] | MSKS[i*8 +: 8]);
            wr(`PLSC_OFS_LOOP_BW + i[7:0], 8'h00);
            rd(`PLSC_OFS_LOOP_BW + i[7:0]);
            chk(rd_val, RSTS[i*8 +: 8] & ~MSKS[i*8 +: 8]);
            wr(`PLSC_OFS_LOOP_BW + i[7:0], RSTS[i*8 +: 8]);
        end
        wr(8'h07, 8'h5a);
        rd(8'h07);
        chk(rd_val, `PLSC_RD_UNMAPPED);
        $display("test registers done");
        wr(`PLSC_OFS_METHOD, 8'h1f);
        repeat (2) @(negedge CLOCK);
        chk(HISTORY_DELAY, 8'h1f);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`PLSC_OFS_CMOS, {i[1:0], 6'h00});
            repeat (2) @(negedge CLOCK);
            chk(CMOS_DRIVE_STRENGTH, i[7:0]);
        end
        chk(CMOS_DRIVE_VALID, 8'h01);
        CMOS_FORMAT = 1'b0;
        repeat (2) @(negedge CLOCK);
        chk(CMOS_DRIVE_VALID, 8'h00);
        $display("test fields done");
        wr(`PLSC_OFS_SEL_HOLD, 8'h40);
        sel(3'b010);
        wr(`PLSC_OFS_SEL_HOLD, 8'h80);
        sel(3'b010);
        wr(`PLSC_OFS_SEL_HOLD, 8'h00);
        sel(3'b100);
        PIN_SELECT_ENABLE = 1'b1;
        wr(`PLSC_OFS_SEL_HOLD, 8'h40);
        sel(3'b100);
        SELECT_INPUT_PIN = 1'b1;
        sel(3'b010);
        wr(`PLSC_OFS_SEL_HOLD, 8'h20);
        sel(3'b001);
        INPUT_ONE_VALID = 1'b0;
        INPUT_TWO_VALID = 1'b0;
        sel(3'b001);
        wr(`PLSC_OFS_SEL_HOLD, 8'h00);
        sel(3'b010);
        PIN_SELECT_ENABLE = 1'b0;
        INPUT_ONE_VALID = 1'b1;
        INPUT_TWO_VALID = 1'b1;
        $display("test manual and hold done");
        wr(`PLSC_OFS_METHOD, 8'h92);
        sel(3'b100);
        INPUT_ONE_VALID = 1'b0;
        sel(3'b010);
        INPUT_ONE_VALID = 1'b1;
        sel(3'b100);
        wr(`PLSC_OFS_METHOD, 8'h52);
        INPUT_ONE_VALID = 1'b0;
        sel(3'b010);
        INPUT_ONE_VALID = 1'b1;
        sel(3'b010);
        INPUT_TWO_VALID = 1'b0;
        sel(3'b100);
        INPUT_ONE_VALID = 1'b0;
        sel(3'b001);
        INPUT_ONE_VALID = 1'b1;
        INPUT_TWO_VALID = 1'b1;
        wr(`PLSC_OFS_METHOD, 8'h12);
        sel(3'b100);
        $display("test automatic done");
        bw_exp = 8'h04;
        for (i = 0; i < 3; i = i + 1)
        begin
            OUTPUT_ALWAYS_ENABLED = (i == 2);
            wr(`PLSC_OFS_SEL_HOLD, (i == 1) ? 8'h00 : 8'h10);
            wr(`PLSC_OFS_LOOP_BW, {i[3:0] + 4'h7, 4'h0});
            chk(LOOP_BW_ACTIVE, bw_exp);
            INTERNAL_CAL_START = 1'b1;
            @(negedge CLOCK);
            INTERNAL_CAL_START = 1'b0;
            wait_busy(1'b1);
            chk(OUTPUT_CLOCK_ENABLE, (i != 0));
            wait_busy(1'b0);
            bw_exp = i[7:0] + 8'h07;
            chk(LOOP_BW_ACTIVE, bw_exp);
            chk(OUTPUT_CLOCK_ENABLE, 8'h01);
        end
        $display("test calibration done");
        end_sim;
    end
endmodule // tb_top
